// ---- fracn_regs_pkg.sv ----
// Contract
// - 19-bit feedback divider, resets to 100
// - Seed apply bit, reset 0
// - Seed writes add to held seed
// - Modulator reset low clears seed, ignores fractions
// - Order 0 integer, 1-4 modulation, rest reserved
// - Output A power field, reset 31
// - Output B powerdown, reset 1
// - Output A powerdown, reset 0
// - Output A source select, reset 1
// - Output current boost, reset 0
// - Output B power field, reset 31
// - Output B source select, reset 1
// - Sync pins ignored unless bit cleared
// - Pin format codes 4-7 invalid
package fracn_regs_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_FB_UP   = 6'h22;
  localparam logic [5:0] IDX_FB_LO   = 6'h24;
  localparam logic [5:0] IDX_SEED_EN = 6'h25;
  localparam logic [5:0] IDX_DEN_UP  = 6'h26;
  localparam logic [5:0] IDX_DEN_LO  = 6'h27;
  localparam logic [5:0] IDX_SEED_UP = 6'h28;
  localparam logic [5:0] IDX_SEED_LO = 6'h29;
  localparam logic [5:0] IDX_NUM_UP  = 6'h2A;
  localparam logic [5:0] IDX_NUM_LO  = 6'h2B;
  localparam logic [5:0] IDX_OUT_MOD = 6'h2C;
  localparam logic [5:0] IDX_OUT_A   = 6'h2D;
  localparam logic [5:0] IDX_OUT_B   = 6'h2E;
  localparam logic [5:0] IDX_SYNC    = 6'h3A;
  // Constant bits that read back in the seed enable, output A, output B and sync registers.
  localparam logic [15:0] FIX_SEED_EN = 16'h0004;
  localparam logic [15:0] FIX_OUT_A   = 16'hC0C0;
  localparam logic [15:0] FIX_OUT_B   = 16'h07FC;
  localparam logic [15:0] FIX_SYNC    = 16'h0001;
  // Reset values and the highest valid order and format.
  localparam logic [18:0] RST_FB_DIV   = 19'h00064;
  localparam logic [5:0]  RST_PD_DLY   = 6'h02;
  localparam logic [31:0] RST_DEN      = 32'hFFFFFFFF;
  localparam logic [5:0]  RST_PWR      = 6'h1F;
  localparam logic [1:0]  RST_SOURCE   = 2'h1;
  localparam logic [2:0]  MAX_ORDER    = 3'h4;
  localparam logic [2:0]  MAX_FMT      = 3'h3;
  // AHB encodings.
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [31:0] HI_ADDR_MASK = 32'hFFFFFF00;
  // Field positions.
  localparam int B_SEED_EN = 15;
  localparam int B_HYST    = 14;
  localparam int B_IGNORE  = 15;
  localparam int B_B_PD    = 7;
  localparam int B_A_PD    = 6;
  localparam int B_MOD_RST = 5;
  localparam int B_FMT_SYN = 0;
  localparam int B_FMT_REQ = 1;
  // Bus state machine.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } bus_state_e;
endpackage

// ---- fracn_divider_output_regs.sv ----
`timescale 1ns/1ps
module fracn_divider_output_regs
  import fracn_regs_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        OSC_PHASE_SYNC_MODE,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [18:0] FB_DIV,
  output logic             MOD_SEED_APPLY,
  output logic      [5:0]  PHASE_DET_DELAY_SEL,
  output logic      [31:0] FRAC_DENOMINATOR,
  output logic      [31:0] MOD_SEED_VALUE,
  output logic      [31:0] FRAC_NUMERATOR,
  output logic      [5:0]  OUT_A_POWER,
  output logic             OUT_B_POWERDOWN,
  output logic             OUT_A_POWERDOWN,
  output logic             MOD_RESET_LOW,
  output logic      [2:0]  MOD_ORDER,
  output logic             FRAC_ACTIVE,
  output logic      [1:0]  OUT_A_SOURCE,
  output logic      [1:0]  OUT_CURRENT_BOOST,
  output logic      [5:0]  OUT_B_POWER,
  output logic      [1:0]  OUT_B_SOURCE,
  output logic             SYNC_PINS_IGNORE,
  output logic             SYNC_PINS_HYSTERESIS,
  output logic      [1:0]  SYNC_PINS_BIAS_LEVEL,
  output logic      [2:0]  SYNC_PINS_FORMAT,
  output logic             SYNC_PINS_USE,
  output logic             SYNC_PIN_LVDS,
  output logic             SYSREF_REQ_LVDS
);

  // Index match; the upper address bits must be zero for a hit.
  function automatic logic hit(input logic [31:0] a,
                               input logic [5:0]  idx);
    hit = ((a & HI_ADDR_MASK) == 32'h00000000) && (a[7:2] == idx);
  endfunction

  bus_state_e  state_q;
  bus_state_e  state_d;
  logic [31:0] addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ready_q;
  logic [18:0] fb_div_q;
  logic        seed_apply_q;
  logic [5:0]  pd_delay_q;
  logic [31:0] den_q;
  logic [31:0] seed_q;
  logic [31:0] seed_d;
  logic [31:0] num_q;
  logic [5:0]  a_power_q;
  logic        b_pd_q;
  logic        a_pd_q;
  logic        mod_rst_low_q;
  logic [2:0]  order_q;
  logic [2:0]  order_eff_q;
  logic        frac_active_q;
  logic [1:0]  a_source_q;
  logic [1:0]  boost_q;
  logic [5:0]  b_power_q;
  logic [1:0]  b_source_q;
  logic        ignore_q;
  logic        hyst_q;
  logic [1:0]  lvl_q;
  logic [2:0]  fmt_q;
  logic        pins_use_q;
  logic        sync_lvds_q;
  logic        req_lvds_q;

  // Only a selected NONSEQ transfer on a ready bus is taken.
  wire        accept = HSEL && HREADY && (HTRANS == HTRANS_NSEQ);
  wire        wr_en  = (state_q == ST_WRITE);
  wire [15:0] wd     = HWDATA[15:0];

  wire wr_fb_up   = wr_en && hit(addr_q, IDX_FB_UP);
  wire wr_fb_lo   = wr_en && hit(addr_q, IDX_FB_LO);
  wire wr_seed_en = wr_en && hit(addr_q, IDX_SEED_EN);
  wire wr_den_up  = wr_en && hit(addr_q, IDX_DEN_UP);
  wire wr_den_lo  = wr_en && hit(addr_q, IDX_DEN_LO);
  wire wr_seed_up = wr_en && hit(addr_q, IDX_SEED_UP);
  wire wr_seed_lo = wr_en && hit(addr_q, IDX_SEED_LO);
  wire wr_num_up  = wr_en && hit(addr_q, IDX_NUM_UP);
  wire wr_num_lo  = wr_en && hit(addr_q, IDX_NUM_LO);
  wire wr_out_mod = wr_en && hit(addr_q, IDX_OUT_MOD);
  wire wr_out_a   = wr_en && hit(addr_q, IDX_OUT_A);
  wire wr_out_b   = wr_en && hit(addr_q, IDX_OUT_B);
  wire wr_sync    = wr_en && hit(addr_q, IDX_SYNC);

  // Reads take one wait state so a write just before is visible.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE, ST_WRITE:
      begin
        if (accept)
          state_d = HWRITE ? ST_WRITE : ST_READ;
        else
          state_d = ST_IDLE;
      end
      ST_READ: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      state_q <= ST_IDLE;
      addr_q  <= 32'h00000000;
      ready_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      if (accept)
        addr_q <= HADDR;
      ready_q <= (state_d != ST_READ);
      rdata_q <= rdata_d;
    end
  end

  // Read word; fixed bits read as their constant, unmapped reads zero.
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (state_q == ST_READ)
    begin
      if (hit(addr_q, IDX_FB_UP))
        rdata_d = {29'h0, fb_div_q[18:16]};
      else if (hit(addr_q, IDX_FB_LO))
        rdata_d = {16'h0, fb_div_q[15:0]};
      else if (hit(addr_q, IDX_SEED_EN))
        rdata_d = {16'h0, seed_apply_q, 1'b0, pd_delay_q,
                   FIX_SEED_EN[7:0]};
      else if (hit(addr_q, IDX_DEN_UP))
        rdata_d = {16'h0, den_q[31:16]};
      else if (hit(addr_q, IDX_DEN_LO))
        rdata_d = {16'h0, den_q[15:0]};
      else if (hit(addr_q, IDX_SEED_UP))
        rdata_d = {16'h0, seed_q[31:16]};
      else if (hit(addr_q, IDX_SEED_LO))
        rdata_d = {16'h0, seed_q[15:0]};
      else if (hit(addr_q, IDX_NUM_UP))
        rdata_d = {16'h0, num_q[31:16]};
      else if (hit(addr_q, IDX_NUM_LO))
        rdata_d = {16'h0, num_q[15:0]};
      else if (hit(addr_q, IDX_OUT_MOD))
        rdata_d = {18'h0, a_power_q, b_pd_q, a_pd_q, mod_rst_low_q,
                   2'h0, order_q};
      else if (hit(addr_q, IDX_OUT_A))
        rdata_d = {16'h0, FIX_OUT_A[15:13], a_source_q, boost_q,
                   FIX_OUT_A[8:6], b_power_q};
      else if (hit(addr_q, IDX_OUT_B))
        rdata_d = {16'h0, FIX_OUT_B[15:2], b_source_q};
      else if (hit(addr_q, IDX_SYNC))
        rdata_d = {16'h0, ignore_q, hyst_q, lvl_q, fmt_q,
                   FIX_SYNC[8:0]};
    end
  end

  // Divider, delay select, numerator and denominator.
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      fb_div_q     <= RST_FB_DIV;
      seed_apply_q <= 1'b0;
      pd_delay_q   <= RST_PD_DLY;
      den_q        <= RST_DEN;
      num_q        <= 32'h00000000;
    end
    else
    begin
      // Each half of a split field changes only on its own write.
      if (wr_fb_up)
        fb_div_q[18:16] <= wd[2:0];
      if (wr_fb_lo)
        fb_div_q[15:0] <= wd;
      // The delay select is not checked against the divider value;
      // keeping the two consistent is left to software.
      if (wr_seed_en)
      begin
        seed_apply_q <= wd[B_SEED_EN];
        pd_delay_q   <= wd[13:8];
      end
      if (wr_den_up)
        den_q[31:16] <= wd;
      if (wr_den_lo)
        den_q[15:0] <= wd;
      if (wr_num_up)
        num_q[31:16] <= wd;
      if (wr_num_lo)
        num_q[15:0] <= wd;
    end
  end

  // Seed accumulates on each write; modulator reset and RST_B are the only clears.
  always_comb
  begin
    seed_d = seed_q;
    // A held modulator reset beats a seed write in the same cycle.
    if (!mod_rst_low_q)
      seed_d = 32'h00000000;
    else if (wr_seed_up)
      seed_d = seed_q + {wd, 16'h0000};
    else if (wr_seed_lo)
      seed_d = seed_q + {16'h0000, wd};
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
      seed_q <= 32'h00000000;
    else
      seed_q <= seed_d;
  end

  // Output power, powerdowns, modulator control and source selects.
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      a_power_q     <= RST_PWR;
      b_pd_q        <= 1'b1;
      a_pd_q        <= 1'b0;
      mod_rst_low_q <= 1'b1;
      order_q       <= 3'h0;
      a_source_q    <= RST_SOURCE;
      boost_q       <= 2'h0;
      b_power_q     <= RST_PWR;
      b_source_q    <= RST_SOURCE;
    end
    else
    begin
      if (wr_out_mod)
      begin
        a_power_q     <= wd[13:8];
        b_pd_q        <= wd[B_B_PD];
        a_pd_q        <= wd[B_A_PD];
        mod_rst_low_q <= wd[B_MOD_RST];
        order_q       <= wd[2:0];
      end
      if (wr_out_a)
      begin
        a_source_q <= wd[12:11];
        boost_q    <= wd[10:9];
        b_power_q  <= wd[5:0];
      end
      if (wr_out_b)
        b_source_q <= wd[1:0];
    end
  end

  // Sync and sysref-request pin configuration.
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      ignore_q <= 1'b1;
      hyst_q   <= 1'b0;
      lvl_q    <= 2'h0;
      fmt_q    <= 3'h0;
    end
    else if (wr_sync)
    begin
      ignore_q <= wd[B_IGNORE];
      hyst_q   <= wd[B_HYST];
      lvl_q    <= wd[13:12];
      fmt_q    <= wd[11:9];
    end
  end

  // Effective controls; reserved orders and invalid formats fall back.
  wire order_ok = (order_q <= MAX_ORDER);
  wire fmt_ok   = (fmt_q <= MAX_FMT);

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      order_eff_q   <= 3'h0;
      frac_active_q <= 1'b0;
      pins_use_q    <= 1'b0;
      sync_lvds_q   <= 1'b0;
      req_lvds_q    <= 1'b0;
    end
    else
    begin
      order_eff_q   <= order_ok ? order_q : 3'h0;
      frac_active_q <= mod_rst_low_q && order_ok &&
                       (order_q != 3'h0);
      pins_use_q    <= !ignore_q && OSC_PHASE_SYNC_MODE &&
                       fmt_ok;
      sync_lvds_q   <= fmt_ok && fmt_q[B_FMT_SYN];
      req_lvds_q    <= fmt_ok && fmt_q[B_FMT_REQ];
    end
  end

  // The bus never signals an error, so its response stays OKAY.
  assign HRDATA               = rdata_q;
  assign HREADYOUT            = ready_q;
  assign HRESP                = 1'b0;
  assign FB_DIV               = fb_div_q;
  assign MOD_SEED_APPLY       = seed_apply_q;
  assign PHASE_DET_DELAY_SEL  = pd_delay_q;
  assign FRAC_DENOMINATOR     = den_q;
  assign MOD_SEED_VALUE       = seed_q;
  assign FRAC_NUMERATOR       = num_q;
  assign OUT_A_POWER          = a_power_q;
  assign OUT_B_POWERDOWN      = b_pd_q;
  assign OUT_A_POWERDOWN      = a_pd_q;
  assign MOD_RESET_LOW        = mod_rst_low_q;
  assign MOD_ORDER            = order_eff_q;
  assign FRAC_ACTIVE          = frac_active_q;
  assign OUT_A_SOURCE         = a_source_q;
  assign OUT_CURRENT_BOOST    = boost_q;
  assign OUT_B_POWER          = b_power_q;
  assign OUT_B_SOURCE         = b_source_q;
  assign SYNC_PINS_IGNORE     = ignore_q;
  assign SYNC_PINS_HYSTERESIS = hyst_q;
  assign SYNC_PINS_BIAS_LEVEL = lvl_q;
  assign SYNC_PINS_FORMAT     = fmt_q;
  assign SYNC_PINS_USE        = pins_use_q;
  assign SYNC_PIN_LVDS        = sync_lvds_q;
  assign SYSREF_REQ_LVDS      = req_lvds_q;

endmodule // fracn_divider_output_regs

// ---- fracn_regs_chk_sva.sv ----
`timescale 1ns/1ps
module fracn_regs_chk
  import fracn_regs_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST_B,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        OSC_PHASE_SYNC_MODE,
  input wire logic [18:0] FB_DIV,
  input wire logic [31:0] MOD_SEED_VALUE,
  input wire logic        MOD_RESET_LOW,
  input wire logic [2:0]  MOD_ORDER,
  input wire logic        FRAC_ACTIVE,
  input wire logic        SYNC_PINS_IGNORE,
  input wire logic [2:0]  SYNC_PINS_FORMAT,
  input wire logic        SYNC_PINS_USE,
  input wire logic        SYNC_PIN_LVDS,
  input wire logic        SYSREF_REQ_LVDS
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  wire take = HSEL && HREADY && HTRANS == HTRANS_NSEQ;
  wire wr_t = take && HWRITE;
  wire rd_t = take && !HWRITE;
  property p_seed_clr;
    !MOD_RESET_LOW |=> MOD_SEED_VALUE == 32'h0;
  endproperty
  a_seed_clr: assert property (p_seed_clr)
    else $error("seed kept while modulator reset");
  property p_seed_src;
    $changed(MOD_SEED_VALUE) && MOD_SEED_VALUE != 32'h0 |-> $past(wr_t, 2);
  endproperty
  a_seed_src: assert property (p_seed_src)
    else $error("seed moved without a write");
  property p_frac;
    FRAC_ACTIVE == ($past(MOD_RESET_LOW) && MOD_ORDER != 3'h0);
  endproperty
  a_frac: assert property (p_frac)
    else $error("fraction enable wrong");
  property p_fbdiv;
    $changed(FB_DIV) |-> $past(wr_t, 2);
  endproperty
  a_fbdiv: assert property (p_fbdiv)
    else $error("divider moved without a write");
  property p_sync;
    SYNC_PINS_USE == $past(!SYNC_PINS_IGNORE && OSC_PHASE_SYNC_MODE
                           && SYNC_PINS_FORMAT <= MAX_FMT);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync pin use wrong");
  property p_lvds;
    {SYSREF_REQ_LVDS, SYNC_PIN_LVDS} == ($past(SYNC_PINS_FORMAT) <= MAX_FMT
      ? $past(SYNC_PINS_FORMAT[1:0]) : 2'h0);
  endproperty
  a_lvds: assert property (p_lvds)
    else $error("pin format decode wrong");
  property p_rd_wait;
    rd_t |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_wr_zero;
    wr_t |=> HREADYOUT [*2];
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("write stalled");
endmodule // fracn_regs_chk
bind fracn_divider_output_regs fracn_regs_chk i_fracn_regs_chk (
  .MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .OSC_PHASE_SYNC_MODE(OSC_PHASE_SYNC_MODE), .FB_DIV(FB_DIV),
  .MOD_SEED_VALUE(MOD_SEED_VALUE), .MOD_RESET_LOW(MOD_RESET_LOW),
  .MOD_ORDER(MOD_ORDER), .FRAC_ACTIVE(FRAC_ACTIVE),
  .SYNC_PINS_IGNORE(SYNC_PINS_IGNORE), .SYNC_PINS_FORMAT(SYNC_PINS_FORMAT),
  .SYNC_PINS_USE(SYNC_PINS_USE), .SYNC_PIN_LVDS(SYNC_PIN_LVDS),
  .SYSREF_REQ_LVDS(SYSREF_REQ_LVDS));

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import fracn_regs_pkg::*;
;
  logic        mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, osc = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed, den, num, rd;
  logic [1:0]  htrans = 0, a_src, boost, b_src, bias;
  logic [18:0] fb;
  logic [5:0]  dly, a_pwr, b_pwr;
  logic [2:0]  order, fmt;
  logic        hready, hresp, s_app, b_pd, a_pd, m_rst, f_act;
  logic        ign, hyst, use_p, s_lvds, r_lvds;
  int          err_total = 0, tests_run = 0;
  always #12.5 mclk = ~mclk;
  fracn_divider_output_regs i_fracn_divider_output_regs (
    .MCLK(mclk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .OSC_PHASE_SYNC_MODE(osc), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .FB_DIV(fb), .MOD_SEED_APPLY(s_app),
    .PHASE_DET_DELAY_SEL(dly), .FRAC_DENOMINATOR(den),
    .MOD_SEED_VALUE(seed), .FRAC_NUMERATOR(num), .OUT_A_POWER(a_pwr),
    .OUT_B_POWERDOWN(b_pd), .OUT_A_POWERDOWN(a_pd), .MOD_RESET_LOW(m_rst),
    .MOD_ORDER(order), .FRAC_ACTIVE(f_act), .OUT_A_SOURCE(a_src),
    .OUT_CURRENT_BOOST(boost), .OUT_B_POWER(b_pwr), .OUT_B_SOURCE(b_src),
    .SYNC_PINS_IGNORE(ign), .SYNC_PINS_HYSTERESIS(hyst),
    .SYNC_PINS_BIAS_LEVEL(bias), .SYNC_PINS_FORMAT(fmt),
    .SYNC_PINS_USE(use_p), .SYNC_PIN_LVDS(s_lvds),
    .SYSREF_REQ_LVDS(r_lvds));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      ck("hready", 1, hready);
      finish_test();
    end
  endtask
  // One single AHB transfer; the read word lands in rd.
  task automatic bus(input logic w, input logic [23:0] hi,
                     input logic [5:0] ix, input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr <= {hi, ix, 2'b00};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {16'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic t_reset;
    logic [5:0] ix [8] = '{IDX_FB_UP, IDX_FB_LO, IDX_SEED_EN, IDX_DEN_LO,
                           IDX_OUT_MOD, IDX_OUT_A, IDX_OUT_B, IDX_SYNC};
    logic [15:0] ex [8] = '{16'h0000, 16'h0064, 16'h0204, 16'hFFFF,
                            16'h1FA0, 16'hC8DF, 16'h07FD, 16'h8001};
    for (int i = 0; i < 8; i++)
    begin
      bus(0, 24'h0, ix[i], 16'h0);
      ck("reset read", {16'h0, ex[i]}, rd);
    end
    ck("fb", 19'h00064, fb);
    ck("den", 32'hFFFFFFFF, den);
    ck("seed num", 32'h0, seed | num);
    ck("dly app", 7'h02, {s_app, dly});
    ck("outs", 24'h1F7D4B, {a_pwr, b_pwr, a_src, b_src, boost, b_pd, a_pd, m_rst, ign});
    $display("t_reset done");
  endtask
  task automatic t_fields;
    logic [1:0] c;
    bus(1, 24'h0, IDX_FB_UP, 16'hFFFF);
    bus(1, 24'h0, IDX_FB_LO, 16'hFFFF);
    bus(0, 24'h0, IDX_FB_UP, 16'h0);
    ck("fb up read", 32'h7, rd);
    ck("fb", 19'h7FFFF, fb);
    bus(1, 24'h0, IDX_SEED_EN, 16'hFFFF);
    bus(0, 24'h0, IDX_SEED_EN, 16'h0);
    ck("seed en read", 32'hBF04, rd);
    ck("dly app", 7'h7F, {s_app, dly});
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      bus(1, 24'h0, IDX_OUT_A, {3'h0, c, c, 3'h0, c, c, c});
      bus(1, 24'h0, IDX_OUT_B, {14'h0, c});
      bus(0, 24'h0, IDX_OUT_A, 16'h0);
      ck("out a read", {16'h0, 16'hC0C0 | {3'h0, c, c, 3'h0, c, c, c}}, rd);
      bus(0, 24'h0, IDX_OUT_B, 16'h0);
      ck("out b read", {16'h0, 16'h07FC | {14'h0, c}}, rd);
      ck("srcs", {c, c, c, c, c, c}, {a_src, boost, b_src, b_pwr});
    end
    bus(1, 24'h0, IDX_NUM_UP, 16'h1234);
    bus(1, 24'h0, IDX_NUM_LO, 16'hABCD);
    bus(1, 24'h0, IDX_DEN_LO, 16'h0000);
    @(posedge mclk);
    ck("num", 32'h1234ABCD, num);
    ck("den", 32'hFFFF0000, den);
    $display("t_fields done");
  endtask
  task automatic t_mod;
    logic [2:0] o;
    bus(1, 24'h0, IDX_SEED_UP, 16'h0001);
    bus(1, 24'h0, IDX_SEED_LO, 16'hFFFF);
    bus(1, 24'h0, IDX_SEED_LO, 16'h0001);
    @(posedge mclk);
    ck("seed sum", 32'h00020000, seed);
    bus(1, 24'h0, IDX_OUT_MOD, 16'h00C0);
    bus(1, 24'h0, IDX_SEED_LO, 16'h0005);
    repeat (2) @(posedge mclk);
    ck("seed clr", 32'h0, seed);
    ck("pd", 9'h180, {b_pd, a_pd, a_pwr, m_rst});
    for (int i = 0; i < 8; i++)
    begin
      o = i[2:0];
      bus(1, 24'h0, IDX_OUT_MOD, {13'h07E4, o});
      bus(0, 24'h0, IDX_OUT_MOD, 16'h0);
      ck("mod read", {16'h0000, 13'h07E4, o}, rd);
      ck("order", {(o <= 3'h4) ? o : 3'h0, o inside {[1:4]}}, {order, f_act});
    end
    $display("t_mod done");
  endtask
  task automatic t_sync;
    logic [2:0] f;
    for (int i = 0; i < 16; i++)
    begin
      f = i[2:0];
      osc <= i[3];
      bus(1, 24'h0, IDX_SYNC, {4'h6, f, 9'h0});
      bus(0, 24'h0, IDX_SYNC, 16'h0);
      ck("sync read", {16'h6001, 16'h0} >> 16 | {f, 9'h0}, rd);
      ck("pins", {i[3] && f <= 3'h3, f <= 3'h3 && f[0], f <= 3'h3 && f[1], 3'h6, f}, {use_p, s_lvds, r_lvds, hyst, bias, fmt});
    end
    bus(1, 24'h0, IDX_SYNC, 16'h8000);
    bus(0, 24'h0, IDX_SYNC, 16'h0);
    ck("ignore", 2'h2, {ign, use_p});
    $display("t_sync done");
  endtask
  task automatic t_unmapped;
    bus(1, 24'h0, 6'h23, 16'h1111);
    bus(1, 24'h1, IDX_FB_LO, 16'h2222);
    bus(0, 24'h0, 6'h23, 16'h0);
    ck("hole read", 32'h0, rd);
    bus(0, 24'h1, IDX_FB_LO, 16'h0);
    ck("high read", 32'h0, rd);
    ck("fb kept", {1'b0, 19'h7FFFF}, {hresp, fb});
    rst_b <= 1'b0;
    repeat (10) @(posedge mclk);
    ck("fb rst", 19'h00064, fb);
    rst_b <= 1'b1;
    @(posedge mclk);
    bus(0, 24'h0, IDX_FB_LO, 16'h0);
    ck("fb lo rst read", 32'h00000064, rd);
    $display("t_unmapped done");
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_fields();
    t_mod();
    t_sync();
    t_unmapped();
    finish_test();
  end
endmodule // tb_top
